// >>> cmbt_can_node.sv
// Behavioural far-side CAN node driving the receive line.
// Assumes a wired-AND bus pulled recessive (high) when nobody sends.
`timescale 1ns/1ps
module cmbt_can_node #(
	parameter int BIT_CLKS = 14
) (
	// Clock
	input wire logic aclk,
	// Control from the bench
	input wire logic send,
	input wire logic [7:0] pattern,
	// Bus line
	output logic can_rx
);
	int cnt = 0;
	logic [2:0] idx = 3'h0;
	// Released bus shows the pull-up level, never a stale bit
	assign can_rx = send ? pattern[idx] : 1'b1;
	always_ff @(posedge aclk) begin
		cnt <= (!send || cnt == BIT_CLKS - 1) ? 0 : cnt + 1;
		if (!send)
			idx <= 3'h0;
		else if (cnt == BIT_CLKS - 1)
			idx <= idx + 3'h1;
	end
endmodule

// >>> cmbt_pkg.sv
// Constants for the CAN object/interrupt/bit-timing configuration slice.
// Assumes an AXI4-Lite master with 32-bit data and a 10 MHz I/O clock.
package cmbt_pkg;
	localparam int CMBT_NOBJ = 6;
	localparam logic [7:0] CMBT_ADDR_GIE = 8'h00;
	localparam logic [7:0] CMBT_ADDR_INUSE = 8'h04;
	localparam logic [7:0] CMBT_ADDR_OBJIE = 8'h08;
	localparam logic [7:0] CMBT_ADDR_OBJSIT = 8'h0c;
	localparam logic [7:0] CMBT_ADDR_BT1 = 8'h10;
	localparam logic [7:0] CMBT_ADDR_BT2 = 8'h14;
	localparam logic [7:0] CMBT_ADDR_BT3 = 8'h18;
	localparam logic [7:0] CMBT_ADDR_TCON = 8'h1c;
	localparam logic [7:0] CMBT_ADDR_IRQST = 8'h20;
	localparam int CMBT_GIE_MASTER = 7;
	localparam int CMBT_GIE_RX = 5;
	localparam int CMBT_GIE_TX = 4;
	localparam int CMBT_GIE_OBJERR = 3;
	localparam int CMBT_GIE_FBUF = 2;
	localparam int CMBT_GIE_GENERR = 1;
	localparam int CMBT_GIE_OVRT = 0;
	localparam int CMBT_BT1_BRP_LSB = 1;
	localparam int CMBT_BT2_SJW_LSB = 5;
	localparam int CMBT_BT2_PRS_LSB = 1;
	localparam int CMBT_BT3_PHASE_SEGMENT_TWO_LSB = 4;
	localparam int CMBT_BT3_PHASE_SEGMENT_ONE_LSB = 1;
	localparam int CMBT_BT3_SMP = 0;
	localparam logic [7:0] CMBT_BT1_MASK = 8'h7e;
	localparam logic [7:0] CMBT_BT2_MASK = 8'h6e;
	localparam logic [7:0] CMBT_BT3_MASK = 8'h7f;
	localparam logic [7:0] CMBT_RST_BYTE = 8'h00;
	localparam int CMBT_TIMER_DIV = 8;
	localparam logic [1:0] CMBT_RESP_OKAY = 2'b00;
	localparam logic [1:0] CMBT_RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {CMBT_SEG_SYNC, CMBT_SEG_PROP, CMBT_SEG_PH1,
		CMBT_SEG_PH2} cmbt_seg_t;
endpackage

// >>> cmbt_props.sv
// Port checker for the CAN object, interrupt and bit-timing slice.
// Assumes one clock, aclk, and a synchronous active-low aresetn.
`timescale 1ns/1ps
module cmbt_props (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus answers
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Event inputs
	input wire logic ctrl_enabled,
	input wire logic [cmbt_pkg::CMBT_NOBJ-1:0] transmit_done_flag,
	input wire logic [cmbt_pkg::CMBT_NOBJ-1:0] receive_done_flag,
	input wire logic [cmbt_pkg::CMBT_NOBJ-1:0] object_err_flag,
	input wire logic frame_buffer_done,
	input wire logic general_err,
	input wire logic timer_overrun,
	// Outputs under watch
	input wire logic [cmbt_pkg::CMBT_NOBJ-1:0] object_irq_pending,
	input wire logic can_irq,
	input wire logic timer_irq,
	input wire logic sample_strobe,
	input wire logic sampled_bit,
	input wire logic timer_tick
);
	import cmbt_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire [CMBT_NOBJ-1:0] obj_ev;
	wire any_ev;
	assign obj_ev = transmit_done_flag | receive_done_flag | object_err_flag;
	assign any_ev = |obj_ev | frame_buffer_done | general_err;
	sequence s_b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	sequence s_r_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	AST_TIMER_IRQ: assert property (timer_irq |-> $past(timer_overrun))
		else $error("timer irq without overrun");
	AST_CAN_IRQ: assert property (can_irq |-> $past(any_ev) || $past(any_ev, 2))
		else $error("can irq without a source event");
	AST_PEND: assert property ((object_irq_pending & ~$past(obj_ev)) == '0)
		else $error("pending bit without object event");
	AST_TICK_GAP: assert property (timer_tick |=> !timer_tick [*7])
		else $error("timer ticks closer than eight clocks");
	AST_TICK_EN: assert property (timer_tick |-> $past(ctrl_enabled))
		else $error("timer tick while controller disabled");
	AST_SAMPLE_GAP: assert property (sample_strobe |=> !sample_strobe [*3])
		else $error("sample strobes closer than a bit");
	AST_BIT_HOLD: assert property (!$stable(sampled_bit) |-> sample_strobe)
		else $error("sampled bit moved without strobe");
	AST_B_HOLD: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_R_HOLD: assert property (s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == '0)
		else $error("upper read bits not zero");
endmodule
bind cmbt_top cmbt_props chk_u (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .ctrl_enabled,
	.transmit_done_flag, .receive_done_flag, .object_err_flag,
	.frame_buffer_done, .general_err, .timer_overrun, .object_irq_pending,
	.can_irq, .timer_irq, .sample_strobe, .sampled_bit, .timer_tick);

// >>> cmbt_top.sv
// CAN configuration slice: interrupt gating, object enables, bit timing.
// Assumes the frame engine supplies per-object done/error pulses and the
// raw bus level on can_rx; events arrive on aclk.
`timescale 1ns/1ps
module cmbt_top (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Controller state from the frame engine and general control
	input wire logic ctrl_enabled,
	input wire logic abort_request,
	input wire logic standby_enter,
	// Per-object events
	input wire logic [cmbt_pkg::CMBT_NOBJ-1:0] object_enable_set,
	input wire logic [cmbt_pkg::CMBT_NOBJ-1:0] object_disable_set,
	input wire logic [cmbt_pkg::CMBT_NOBJ-1:0] object_auto_reply,
	input wire logic [cmbt_pkg::CMBT_NOBJ-1:0] transmit_done_flag,
	input wire logic [cmbt_pkg::CMBT_NOBJ-1:0] receive_done_flag,
	input wire logic [cmbt_pkg::CMBT_NOBJ-1:0] object_err_flag,
	// General interrupt sources
	input wire logic frame_buffer_done,
	input wire logic general_err,
	input wire logic timer_overrun,
	// Interrupt outputs
	output logic [cmbt_pkg::CMBT_NOBJ-1:0] object_irq_pending,
	output logic can_irq,
	output logic timer_irq,
	// Bit timing
	input wire logic can_rx,
	input wire logic resync_edge_en,
	output logic quantum_tick,
	output logic sample_strobe,
	output logic sampled_bit,
	output logic bit_start,
	output logic timer_tick
);
	import cmbt_pkg::*;

	localparam int N = CMBT_NOBJ;

	logic [7:0] gie, bt1, bt2, bt3, tcon;
	logic [N-1:0] object_in_use, object_irq_en;

	// Write channel: address and data may arrive in either order
	logic aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	wire wr_go = aw_held && w_held;
	wire wr_lane0 = wr_go && w_strb[0];
	wire [7:0] wr_byte = w_data[7:0];
	wire wr_map = aw_addr == CMBT_ADDR_GIE || aw_addr == CMBT_ADDR_INUSE ||
		aw_addr == CMBT_ADDR_OBJIE || aw_addr == CMBT_ADDR_OBJSIT ||
		aw_addr == CMBT_ADDR_BT1 || aw_addr == CMBT_ADDR_BT2 ||
		aw_addr == CMBT_ADDR_BT3 || aw_addr == CMBT_ADDR_TCON ||
		aw_addr == CMBT_ADDR_IRQST;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= CMBT_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? CMBT_RESP_OKAY : CMBT_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register writes; reserved bit-timing bits are dropped on the way in, GIE bit 6 is kept
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gie <= CMBT_RST_BYTE;
			object_irq_en <= '0;
			bt1 <= CMBT_RST_BYTE;
			bt2 <= CMBT_RST_BYTE;
			bt3 <= CMBT_RST_BYTE;
			tcon <= CMBT_RST_BYTE;
		end else if (wr_lane0) begin
			case (aw_addr)
				CMBT_ADDR_GIE: gie <= wr_byte;
				CMBT_ADDR_OBJIE: object_irq_en <= wr_byte[N-1:0];
				CMBT_ADDR_BT1: bt1 <= wr_byte & CMBT_BT1_MASK;
				CMBT_ADDR_BT2: bt2 <= wr_byte & CMBT_BT2_MASK;
				CMBT_ADDR_BT3: bt3 <= wr_byte & CMBT_BT3_MASK;
				CMBT_ADDR_TCON: tcon <= wr_byte;
				default: ;
			endcase
		end
	end

	// In-use tracking; a set in the same cycle as a clear wins
	logic [N-1:0] inuse_clr, next_in_use;
	assign inuse_clr = ((transmit_done_flag |
		(receive_done_flag & ~object_auto_reply)) | object_disable_set |
		{N{abort_request | standby_enter}});
	assign next_in_use = (object_in_use & ~inuse_clr) | object_enable_set;
	always_ff @(posedge aclk) begin
		if (!aresetn) object_in_use <= '0;
		else object_in_use <= next_in_use;
	end

	// Per-object pending vector, gated by per-object and general enables
	wire [N-1:0] tx_src = transmit_done_flag &
		{N{gie[CMBT_GIE_TX]}};
	wire [N-1:0] rx_src = receive_done_flag & ~object_auto_reply &
		{N{gie[CMBT_GIE_RX]}};
	wire [N-1:0] er_src = object_err_flag &
		{N{gie[CMBT_GIE_OBJERR]}};
	wire [N-1:0] next_pending = (tx_src | rx_src | er_src) & object_irq_en;
	wire fbuf_src = frame_buffer_done && gie[CMBT_GIE_FBUF];
	wire gerr_src = general_err && gie[CMBT_GIE_GENERR];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			object_irq_pending <= '0;
			can_irq <= 1'b0;
			timer_irq <= 1'b0;
		end else begin
			object_irq_pending <= next_pending;
			can_irq <= gie[CMBT_GIE_MASTER] &&
				(|next_pending || fbuf_src || gerr_src);
			timer_irq <= timer_overrun && gie[CMBT_GIE_OVRT];
		end
	end

	// Read channel
	function automatic logic [31:0] cmbt_word(input logic [7:0] b);
		cmbt_word = {24'h00_0000, b};
	endfunction
	logic [7:0] ar_addr;
	assign ar_addr = {s_axi_araddr[7:2], 2'b00};
	logic [31:0] rd_word;
	logic rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		case (ar_addr)
			CMBT_ADDR_GIE: rd_word = cmbt_word(gie);
			CMBT_ADDR_INUSE: rd_word = cmbt_word({2'b00, object_in_use});
			CMBT_ADDR_OBJIE: rd_word = cmbt_word({2'b00, object_irq_en});
			CMBT_ADDR_OBJSIT: rd_word = cmbt_word({2'b00, object_irq_pending});
			CMBT_ADDR_BT1: rd_word = cmbt_word(bt1);
			CMBT_ADDR_BT2: rd_word = cmbt_word(bt2);
			CMBT_ADDR_BT3: rd_word = cmbt_word(bt3);
			CMBT_ADDR_TCON: rd_word = cmbt_word(tcon);
			CMBT_ADDR_IRQST: rd_word = cmbt_word({6'h00, timer_irq, can_irq});
			default: begin
				rd_word = 32'h0000_0000;
				rd_ok = 1'b0;
			end
		endcase
	end
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= CMBT_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? CMBT_RESP_OKAY : CMBT_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Bus input synchroniser: the first stage feeds only the second
	logic rx_meta, rx_sync, rx_prev, rx_d1, rx_d2;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
			rx_prev <= 1'b1;
			rx_d1 <= 1'b1;
			rx_d2 <= 1'b1;
		end else begin
			rx_meta <= can_rx;
			rx_sync <= rx_meta;
			rx_prev <= rx_sync;
			rx_d1 <= rx_sync;
			rx_d2 <= rx_d1;
		end
	end

	// Quantum prescaler
	wire [5:0] quantum_prescaler = bt1[CMBT_BT1_BRP_LSB +: 6];
	wire [1:0] resync_jump_width = bt2[CMBT_BT2_SJW_LSB +: 2];
	wire [2:0] propagation_segment = bt2[CMBT_BT2_PRS_LSB +: 3];
	wire [2:0] ph2 = bt3[CMBT_BT3_PHASE_SEGMENT_TWO_LSB +: 3];
	wire [2:0] ph1 = bt3[CMBT_BT3_PHASE_SEGMENT_ONE_LSB +: 3];
	wire triple = bt3[CMBT_BT3_SMP];
	logic [5:0] q_cnt;
	wire q_last = q_cnt == quantum_prescaler;
	assign quantum_tick = q_last;
	always_ff @(posedge aclk) begin
		if (!aresetn) q_cnt <= '0;
		else q_cnt <= q_last ? 6'd0 : q_cnt + 6'd1;
	end

	// Segment sequencer; lengths are field plus one quanta
	cmbt_seg_t seg;
	logic [3:0] seg_cnt;
	logic [3:0] ph1_len, ph2_len;
	wire [3:0] sjw_q = {2'b00, resync_jump_width} + 4'd1;
	wire falling = rx_prev && !rx_sync && resync_edge_en;
	wire [3:0] ph1_min = {1'b0, ph1};
	wire [3:0] prs_end = {1'b0, propagation_segment};
	wire seg_end = seg_cnt == (seg == CMBT_SEG_PROP ? prs_end :
		seg == CMBT_SEG_PH1 ? ph1_len : seg == CMBT_SEG_PH2 ? ph2_len : 4'd0);
	// Edge in phase two restarts the bit only within the jump width
	wire [3:0] ph2_left = ph2_len - seg_cnt;
	wire early_cut = falling && seg == CMBT_SEG_PH2 && ph2_left < sjw_q;
	// Sample point is the last I/O clock of phase one
	wire at_sp = seg == CMBT_SEG_PH1 && seg_end && q_last;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seg <= CMBT_SEG_SYNC;
			seg_cnt <= '0;
			ph1_len <= '0;
			ph2_len <= '0;
		end else if (early_cut) begin
			// Early edge: cut phase two short and start a new bit
			seg <= CMBT_SEG_SYNC;
			seg_cnt <= '0;
		end else begin
			if (falling && seg == CMBT_SEG_PH2)
				// Too early to absorb: shorten by the jump width only
				ph2_len <= ph2_len - sjw_q;
			if (falling && (seg == CMBT_SEG_PROP || seg == CMBT_SEG_PH1))
				// Late edge: stretch phase one by up to the jump width
				ph1_len <= ph1_min + (seg_cnt < sjw_q ? seg_cnt : sjw_q);
			if (q_last) begin
				if (seg_end) begin
					seg_cnt <= '0;
					case (seg)
						CMBT_SEG_SYNC: seg <= CMBT_SEG_PROP;
						CMBT_SEG_PROP: seg <= CMBT_SEG_PH1;
						CMBT_SEG_PH1: begin
							seg <= CMBT_SEG_PH2;
							ph2_len <= {1'b0, ph2};
						end
						CMBT_SEG_PH2: begin
							seg <= CMBT_SEG_SYNC;
							ph1_len <= ph1_min;
						end
						default: seg <= CMBT_SEG_SYNC;
					endcase
				end else begin
					seg_cnt <= seg_cnt + 4'd1;
				end
			end
		end
	end
	assign bit_start = seg == CMBT_SEG_SYNC && q_cnt == 6'd0;

	// Sampling: one point, or majority of three consecutive I/O clocks
	wire majority = (rx_sync & rx_d1) | (rx_sync & rx_d2) | (rx_d1 & rx_d2);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sampled_bit <= 1'b1;
			sample_strobe <= 1'b0;
		end else begin
			sample_strobe <= at_sp;
			if (at_sp)
				sampled_bit <= triple ? majority : rx_sync;
		end
	end

	// Bus timer prescaler, running only while the controller is enabled
	logic [2:0] t8_cnt;
	logic [7:0] tp_cnt;
	wire t8_last = t8_cnt == 3'(CMBT_TIMER_DIV - 1);
	wire tp_last = t8_last && tp_cnt == tcon;
	always_ff @(posedge aclk) begin
		if (!aresetn || !ctrl_enabled) begin
			t8_cnt <= '0;
			tp_cnt <= '0;
			timer_tick <= 1'b0;
		end else begin
			t8_cnt <= t8_cnt + 3'd1;
			if (t8_last)
				tp_cnt <= tp_last ? 8'd0 : tp_cnt + 8'd1;
			timer_tick <= tp_last;
		end
	end
endmodule

// >>> cmbt_top_test.sv
// Bench for the CAN slice: registers, object use, irq gating, timing.
// Assumes the bound checker and a far-side node on can_rx.
`timescale 1ns/1ps
module cmbt_top_test;
	import cmbt_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr, pat, seen;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, rs;
	logic awready, wready, bvalid, arready, rvalid, can_rx, send;
	logic ctrl_en, abort_req, standby, resync_en, fbuf, gerr, ovr;
	logic [5:0] en_set, dis_set, auto_rep, txd, rxd, errf, pend;
	logic can_irq, timer_irq, qtick, sstb, sbit, bstart, ttick;
	int n_fail = 0, num_checks = 0, cyc = 0, n;
	int uk[9] = '{6, 0, 1, 1, 0, 7, 8, 6, 9};
	logic [7:0] um[9] = '{8'h3f, 8'h01, 8'h02, 8'h04, 8'h04, 8'h08, 8'h00,
		8'h3f, 8'h00};
	logic [7:0] ue[9] = '{8'h3f, 8'h3e, 8'h3c, 8'h3c, 8'h38, 8'h30, 8'h00,
		8'h3f, 8'h00};
	logic [7:0] gg[14] = '{8'hb0, 8'h80, 8'h10, 8'ha0, 8'h80, 8'h88, 8'h80,
		8'h84, 8'h80, 8'h82, 8'h80, 8'h01, 8'h00, 8'hfe};
	int gk[14] = '{0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 5, 5, 5};
	int ge[14] = '{1, 0, 0, 1, 0, 1, 0, 1, 0, 1, 0, 2, 0, 0};
	logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h1c, 8'h20};
	cmbt_top dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ctrl_enabled(ctrl_en),
		.abort_request(abort_req), .standby_enter(standby),
		.object_enable_set(en_set), .object_disable_set(dis_set),
		.object_auto_reply(auto_rep), .transmit_done_flag(txd),
		.receive_done_flag(rxd), .object_err_flag(errf),
		.frame_buffer_done(fbuf), .general_err(gerr), .timer_overrun(ovr),
		.object_irq_pending(pend), .can_irq(can_irq), .timer_irq(timer_irq),
		.can_rx(can_rx), .resync_edge_en(resync_en), .quantum_tick(qtick),
		.sample_strobe(sstb), .sampled_bit(sbit), .bit_start(bstart),
		.timer_tick(ttick));
	cmbt_can_node node_u (.aclk(aclk), .send(send), .pattern(pat),
		.can_rx(can_rx));
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Waits for the answer as long as it takes; only the run timeout ends it
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		{awaddr, wdata} <= {a, d};
		{awvalid, wvalid, bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		{d, r} = {rdata, rresp};
		rready <= 1'b0;
	endtask
	// Kinds 0..5 are irq sources, 6..9 change object use
	task automatic fire(input int k, input logic [5:0] m, output logic [7:0] s);
		s = 8'h00;
		@(posedge aclk);
		{txd, rxd, errf} <= {k == 0 ? m : 6'h0, k == 1 ? m : 6'h0,
			k == 2 ? m : 6'h0};
		{fbuf, gerr, ovr, abort_req, standby} <= {k == 3, k == 4, k == 5,
			k == 8, k == 9};
		{en_set, dis_set} <= {k == 6 ? m : 6'h0, k == 7 ? m : 6'h0};
		@(posedge aclk);
		{txd, rxd, errf, fbuf, gerr, ovr, abort_req, standby} <= '0;
		{en_set, dis_set} <= '0;
		repeat (3) begin
			@(posedge aclk);
			s = s | {pend, timer_irq, can_irq};
		end
	endtask
	// Gap between two ticks of quantum (0), bit start (1) or timer (2)
	task automatic gap(input int w, output int g);
		int p, t;
		{p, t, g} = '0;
		while (p < 2 && t < 400) begin
			@(posedge aclk);
			t++;
			if (p == 1) g++;
			if ((w == 0) ? qtick : (w == 1) ? bstart : ttick) p++;
		end
		if (p < 2) g = 0;
	endtask
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} = '0;
		{wdata, ctrl_en, abort_req, standby, resync_en, send, pat} = '0;
		{en_set, dis_set, auto_rep, txd, rxd, errf, fbuf, gerr, ovr} = '0;
		aresetn = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		ctrl_en <= 1'b1;
		foreach (ra[i]) begin
			axi_rd(ra[i], rd, rs);
			chk_val(rd, 32'h0);
		end
		axi_rd(8'h24, rd, rs);
		chk_resp(rs, CMBT_RESP_SLVERR);
		axi_wr(CMBT_ADDR_OBJIE, 32'h3f, rs);
		chk_resp(rs, CMBT_RESP_OKAY);
		axi_rd(CMBT_ADDR_OBJIE, rd, rs);
		chk_val(rd, 32'h3f);
		for (int i = 0; i < 9; i++) begin
			if (i == 1) auto_rep <= 6'h04;
			fire(uk[i], um[i][5:0], seen);
			axi_rd(CMBT_ADDR_INUSE, rd, rs);
			chk_val(rd, {24'h00_0000, ue[i]});
		end
		for (int i = 0; i < 14; i++) begin
			axi_wr(CMBT_ADDR_GIE, {24'h00_0000, gg[i]}, rs);
			fire(gk[i], 6'h01, seen);
			chk_val(32'(seen[1:0]), 32'(ge[i]));
		end
		axi_wr(CMBT_ADDR_OBJIE, 32'h3e, rs);
		axi_wr(CMBT_ADDR_GIE, 32'hb0, rs);
		fire(0, 6'h01, seen);
		chk_val(32'(seen), 32'h0);
		fire(0, 6'h02, seen);
		chk_val(32'(seen), 32'h9);
		axi_wr(CMBT_ADDR_BT1, 32'h2, rs);
		axi_wr(CMBT_ADDR_BT2, 32'h2, rs);
		axi_wr(CMBT_ADDR_BT3, 32'h12, rs);
		axi_rd(CMBT_ADDR_BT3, rd, rs);
		chk_val(rd, 32'h12);
		gap(0, n);
		chk_val(32'(n), 32'h2);
		gap(1, n);
		chk_val(32'(n), 32'he);
		{resync_en, send} <= 2'h3;
		repeat (60) @(posedge aclk);
		chk_val(32'(sbit), 32'h0);
		axi_wr(CMBT_ADDR_BT3, 32'h13, rs);
		repeat (60) @(posedge aclk);
		chk_val(32'(sbit), 32'h0);
		send <= 1'b0;
		repeat (60) @(posedge aclk);
		chk_val(32'(sbit), 32'h1);
		for (int v = 0; v < 3; v++) begin
			axi_wr(CMBT_ADDR_TCON, 32'(v), rs);
			gap(2, n);
			chk_val(32'(n), 32'(CMBT_TIMER_DIV * (v + 1)));
		end
		ctrl_en <= 1'b0;
		gap(2, n);
		chk_val(32'(n), 32'h0);
		give_verdict();
	end
endmodule
